//--- design/dsi_map.svh
// Register offsets, bit positions, reset values and timing for the duty/standby interlock logic
`ifndef DSI_MAP_SVH
`define DSI_MAP_SVH
// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00C
`define OFF_EDIT 12'h010
`define OFF_PEEK 12'h014
// Control register bits
`define CB_DS_EN 0
`define CB_REMOTE_RST 1
`define CB_MONITOR 2
`define CB_UC_RST 3
`define CB_ESD_RST 4
`define CB_LOCK_RST 5
`define CB_EDIT 6
`define CB_STOP_LATCH 7
`define CTRL_W 8
`define CTRL_RST 8'h00
`define MASK_RST 4'h0
// Switch scan vector positions (1 = healthy / closed)
`define SW_TRAVEL_A 0
`define SW_TRAVEL_B 1
`define SW_CLEAR 2
`define SW_UNIT 3
`define SW_MODE 4
`define SW_START_A 5
`define SW_START_B 6
`define SW_ISO 7
`define SW_PLANT 8
`define SW_PSTOP 9
`define SW_ESD 10
`define SW_RST_UC 11
`define SW_RST_ESD 12
`define SW_RST_LOCK 13
`define SW_SENSE 14
`define NUM_SW 15
// Key and fault vector positions
`define K_RESET 0
`define K_START_A 1
`define K_START_B 2
`define K_STOP 3
`define K_UP 4
`define K_DOWN 5
`define K_STORE 6
`define K_FAULT_A 7
`define K_FAULT_B 8
`define K_UC 9
`define NUM_KEY 10
// Trip kinds
`define T_LOCK 0
`define T_UC 1
`define T_ESD 2
`define T_FSTOP 3
`define T_PSTOP 4
`define T_ISO 5
`define T_PLANT 6
`define NUM_TRIP 7
// Interrupt events
`define E_TRIP 0
`define E_ALARM 1
`define E_DISCARD 2
`define E_TRAVEL 3
`define NUM_EV 4
// Label store
`define NAME_LEN 20
`define NUM_LABELS 12
`define CHAR_SPACE 8'h20
// Scan timing
`define SCAN_TIME_US 1000
`define CLK_MHZ 125
`endif

//--- design/dsi_pkg.sv
// Types shared by the duty/standby interlock logic
package dsi_pkg;
	typedef logic [7:0] char_t;
	typedef logic [3:0] label_t;
	typedef logic [4:0] pos_t;
	typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_ACK = 2'b01} apb_state_t;
endpackage : dsi_pkg

//--- design/duty_standby_interlock_logic.sv
// Interlock switch scan, duty/standby selection, trip handling and label editing
//
// The APB interface to the registers and the register addresses were decided locally.
`include "dsi_map.svh"
// Functional notes
// - Travel limit A open drops contactor A
// - Travel limit A open rejects start A
// - Travel limit B open drops B, rejects
// - Wired clear assigned disables panel reset key
// - Wired clear skips trips with dedicated resets
// - Manual mode: unit choice picks motor
// - Alternation input picks manual or automatic
// - Automatic: even count A, odd count B
// - Tripped motor barred; starts go elsewhere
// - First trip becomes alarm; reset needed
// - Second motor trip stays tripped
// - Stop and shutdown trips need manual reset
// - Isolator, plant trips clear when healthy
// - Commit scan only with healthy sense
// - Unhealthy sense discards scans as undervoltage
// - Up/down step char; store saves, advances
// - Twenty-char labels for ten, tally, unit
module duty_standby_interlock_logic
	import dsi_pkg::*;
#(
	parameter int SCAN_CYCLES = `SCAN_TIME_US * `CLK_MHZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic travel_a_in,
	input wire logic travel_b_in,
	input wire logic trip_clear_in,
	input wire logic unit_choice_input,
	input wire logic alternation_mode_input,
	input wire logic start_a_in,
	input wire logic start_b_in,
	input wire logic isolator_in,
	input wire logic plant_in,
	input wire logic process_stop_in,
	input wire logic emergency_shutdown,
	input wire logic uc_reset_in,
	input wire logic esd_reset_in,
	input wire logic lockout_reset_in,
	input wire logic sense_in,
	input wire logic key_reset,
	input wire logic key_start_a,
	input wire logic key_start_b,
	input wire logic key_stop,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic key_store,
	input wire logic fault_a,
	input wire logic fault_b,
	input wire logic undercurrent_fault,
	output logic contactor_a,
	output logic contactor_b,
	output logic trip_ind,
	output logic alarm_ind,
	output logic irq
);
	localparam int NSYNC = `NUM_SW + `NUM_KEY;
	localparam int NCHARS = `NAME_LEN * `NUM_LABELS;

	// Byte-lane merge of a write into an existing register word
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// Flat label store address
	function automatic logic [7:0] name_idx(input label_t s, input pos_t p);
		return 8'(s * `NAME_LEN + p);
	endfunction : name_idx

	logic [NSYNC-1:0] sync1_ff; // First stage, read only by second stage
	logic [NSYNC-1:0] sync2_ff; // Safe copy of all pins
	logic [`NUM_KEY-1:0] key_old_ff; // For key and fault edges
	logic [`NUM_KEY-1:0] kp; // One-cycle key/fault pulses
	logic [`NUM_SW-1:0] sw_ff; // Committed scan values
	logic [`NUM_SW-1:0] sw_old_ff; // Previous committed scan
	logic upd_ff; // Scan committed last cycle
	logic [23:0] scan_cnt_ff;
	logic scan_tick;
	logic scan_ok;
	logic [`NUM_SW-1:0] rise; // Healthy-going switch edges at commit
	logic [`NUM_SW-1:0] fall; // Unhealthy-going switch edges at commit
	logic [`CTRL_W-1:0] ctrl_ff;
	logic [`NUM_EV-1:0] irq_stat_ff;
	logic [`NUM_EV-1:0] irq_mask_ff;
	logic [`NUM_EV-1:0] ev;
	logic [`NUM_TRIP-1:0] trip_ff;
	logic [`NUM_TRIP-1:0] trip_set;
	logic [`NUM_TRIP-1:0] trip_clr;
	logic alarm_a_ff;
	logic alarm_b_ff;
	logic cnt_odd_ff; // Parity of duty/standby starts
	logic contactor_a_ff;
	logic contactor_b_ff;
	logic trip_ind_ff;
	logic alarm_ind_ff;
	logic irq_ff;
	logic ds_en, auto_mode, remote_en, manual_rst, any_trip;
	logic req_a, req_b, tgt_b, go_a, go_b, stop_a, stop_b;
	logic lock_a, lock_b;
	char_t name_mem [NCHARS]; // All label characters
	label_t edit_sel_ff;
	pos_t cursor_ff;
	char_t edit_char_ff;
	label_t peek_sel_ff;
	pos_t peek_pos_ff;
	apb_state_t apb_st_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic pready_ff; // Answer strobe, high for one cycle
	logic [31:0] ctrl_wr, mask_wr, peek_wr; // Register words after a lane merge
	logic acc_done, acc_wr, acc_rd;
	logic [31:0] rd_mux;
	logic rd_hit;
	char_t peek_char;

	assign contactor_a = contactor_a_ff;
	assign contactor_b = contactor_b_ff;
	assign trip_ind = trip_ind_ff;
	assign alarm_ind = alarm_ind_ff;
	assign irq = irq_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Two-flop synchroniser for every pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			key_old_ff <= '0;
		end else begin
			sync1_ff <= {undercurrent_fault, fault_b, fault_a, key_store, key_down, key_up,
				key_stop, key_start_b, key_start_a, key_reset, sense_in, lockout_reset_in,
				esd_reset_in, uc_reset_in, emergency_shutdown, process_stop_in, plant_in,
				isolator_in, start_b_in, start_a_in, alternation_mode_input,
				unit_choice_input, trip_clear_in, travel_b_in, travel_a_in};
			sync2_ff <= sync1_ff;
			key_old_ff <= sync2_ff[NSYNC-1:`NUM_SW];
		end
	end
	assign kp = sync2_ff[NSYNC-1:`NUM_SW] & ~key_old_ff;

	// Scan period timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_cnt_ff <= '0;
		end else if (scan_tick) begin
			scan_cnt_ff <= '0;
		end else begin
			scan_cnt_ff <= scan_cnt_ff + 24'h000001;
		end
	end
	assign scan_tick = (scan_cnt_ff == 24'(SCAN_CYCLES - 1));
	assign scan_ok = !ctrl_ff[`CB_MONITOR] || sync2_ff[`SW_SENSE];

	// Whole scan is committed at once; relays act on it the cycle after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_ff <= '0;
			sw_old_ff <= '0;
			upd_ff <= 1'b0;
		end else begin
			upd_ff <= scan_tick && scan_ok;
			if (scan_tick && scan_ok) begin
				sw_ff <= sync2_ff[`NUM_SW-1:0];
				sw_old_ff <= sw_ff;
			end
		end
	end
	assign rise = upd_ff ? (sw_ff & ~sw_old_ff) : '0;
	assign fall = upd_ff ? (~sw_ff & sw_old_ff) : '0;

	// Mode and reset decode
	always_comb begin
		ds_en = ctrl_ff[`CB_DS_EN];
		auto_mode = sw_ff[`SW_MODE];
		remote_en = ctrl_ff[`CB_REMOTE_RST];
		// Wired clear replaces the panel key entirely
		manual_rst = remote_en ? rise[`SW_CLEAR] : kp[`K_RESET];
		any_trip = |trip_ff;
	end

	// Start routing; duty/standby sends either start to one chosen motor
	always_comb begin
		req_a = kp[`K_START_A] || rise[`SW_START_A];
		req_b = kp[`K_START_B] || rise[`SW_START_B];
		if (!auto_mode) begin
			tgt_b = sw_ff[`SW_UNIT];
		end else if (alarm_a_ff) begin
			tgt_b = 1'b1;
		end else if (alarm_b_ff) begin
			tgt_b = 1'b0;
		end else begin
			tgt_b = cnt_odd_ff;
		end
		lock_a = !sw_ff[`SW_TRAVEL_A] || alarm_a_ff || any_trip;
		lock_b = !sw_ff[`SW_TRAVEL_B] || alarm_b_ff || any_trip;
		if (ds_en) begin
			go_a = (req_a || req_b) && !tgt_b && !lock_a;
			go_b = (req_a || req_b) && tgt_b && !lock_b;
		end else begin
			go_a = req_a && !lock_a;
			go_b = req_b && !lock_b;
		end
		stop_a = !sw_ff[`SW_TRAVEL_A] || kp[`K_STOP] || kp[`K_FAULT_A] || any_trip;
		stop_b = !sw_ff[`SW_TRAVEL_B] || kp[`K_STOP] || kp[`K_FAULT_B] || any_trip;
	end

	// Contactor relays and start parity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contactor_a_ff <= 1'b0;
			contactor_b_ff <= 1'b0;
			cnt_odd_ff <= 1'b0;
		end else begin
			// Stop outranks a start seen in the same cycle
			contactor_a_ff <= stop_a ? 1'b0 : (go_a ? 1'b1 : contactor_a_ff);
			contactor_b_ff <= stop_b ? 1'b0 : (go_b ? 1'b1 : contactor_b_ff);
			if (ds_en && (go_a || go_b)) begin
				cnt_odd_ff <= !cnt_odd_ff;
			end
		end
	end

	// Trip causes and their per-kind clearing
	always_comb begin
		trip_set = '0;
		trip_clr = '0;
		// A fault becomes an alarm only while the other motor is still usable
		if ((kp[`K_FAULT_A] && !(ds_en && auto_mode && !alarm_b_ff && !any_trip))
			|| (kp[`K_FAULT_B] && !(ds_en && auto_mode && !alarm_a_ff && !any_trip))) begin
			trip_set[`T_LOCK] = 1'b1;
		end
		trip_set[`T_UC] = kp[`K_UC];
		trip_set[`T_ESD] = fall[`SW_ESD];
		trip_set[`T_FSTOP] = kp[`K_STOP] && ctrl_ff[`CB_STOP_LATCH];
		trip_set[`T_PSTOP] = fall[`SW_PSTOP] && ctrl_ff[`CB_STOP_LATCH];
		trip_set[`T_ISO] = !sw_ff[`SW_ISO];
		trip_set[`T_PLANT] = !sw_ff[`SW_PLANT];
		// Dedicated reset inputs own their trips; generic reset skips them
		trip_clr[`T_LOCK] = ctrl_ff[`CB_LOCK_RST] ? sw_ff[`SW_RST_LOCK] : manual_rst;
		trip_clr[`T_UC] = ctrl_ff[`CB_UC_RST] ? sw_ff[`SW_RST_UC] : manual_rst;
		trip_clr[`T_ESD] = ctrl_ff[`CB_ESD_RST] ? sw_ff[`SW_RST_ESD] : manual_rst;
		trip_clr[`T_FSTOP] = manual_rst;
		trip_clr[`T_PSTOP] = manual_rst;
		trip_clr[`T_ISO] = sw_ff[`SW_ISO];
		trip_clr[`T_PLANT] = sw_ff[`SW_PLANT];
	end

	// Trip and alarm flags; a new cause wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_ff <= '0;
			alarm_a_ff <= 1'b0;
			alarm_b_ff <= 1'b0;
			trip_ind_ff <= 1'b0;
			alarm_ind_ff <= 1'b0;
		end else begin
			trip_ff <= trip_set | (trip_ff & ~trip_clr);
			if (kp[`K_FAULT_A] && ds_en && auto_mode && !alarm_b_ff && !any_trip) begin
				alarm_a_ff <= 1'b1;
			end else if (manual_rst) begin
				alarm_a_ff <= 1'b0;
			end
			if (kp[`K_FAULT_B] && ds_en && auto_mode && !alarm_a_ff && !any_trip) begin
				alarm_b_ff <= 1'b1;
			end else if (manual_rst) begin
				alarm_b_ff <= 1'b0;
			end
			trip_ind_ff <= any_trip;
			alarm_ind_ff <= alarm_a_ff || alarm_b_ff;
		end
	end

	// Label editing from the keypad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCHARS; i++) begin
				name_mem[i] <= `CHAR_SPACE;
			end
			edit_sel_ff <= '0;
			cursor_ff <= '0;
			edit_char_ff <= `CHAR_SPACE;
		end else if (acc_wr && paddr == `OFF_EDIT && pstrb[0]
			&& pwdata[3:0] < 4'(`NUM_LABELS)) begin
			// Selecting a label restarts editing at its first character
			edit_sel_ff <= pwdata[3:0];
			cursor_ff <= '0;
			edit_char_ff <= name_mem[name_idx(pwdata[3:0], '0)];
		end else if (ctrl_ff[`CB_EDIT]) begin
			if (kp[`K_STORE]) begin
				name_mem[name_idx(edit_sel_ff, cursor_ff)] <= edit_char_ff;
				if (cursor_ff == 5'(`NAME_LEN - 1)) begin
					cursor_ff <= '0;
					edit_char_ff <= name_mem[name_idx(edit_sel_ff, '0)];
				end else begin
					cursor_ff <= cursor_ff + 5'h01;
					edit_char_ff <= name_mem[name_idx(edit_sel_ff, cursor_ff + 5'h01)];
				end
			end else if (kp[`K_UP]) begin
				edit_char_ff <= edit_char_ff + 8'h01;
			end else if (kp[`K_DOWN]) begin
				edit_char_ff <= edit_char_ff - 8'h01;
			end
		end
	end

	// Interrupt events
	always_comb begin
		ev = '0;
		ev[`E_TRIP] = |(trip_set & ~trip_ff);
		// Only a fault that really turns into an alarm raises the alarm event
		ev[`E_ALARM] = ((kp[`K_FAULT_A] && !alarm_b_ff) || (kp[`K_FAULT_B] && !alarm_a_ff))
			&& ds_en && auto_mode && !any_trip;
		ev[`E_DISCARD] = scan_tick && !scan_ok;
		ev[`E_TRAVEL] = (contactor_a_ff && !sw_ff[`SW_TRAVEL_A])
			|| (contactor_b_ff && !sw_ff[`SW_TRAVEL_B]);
	end

	// Merged write words; a select on a call result is not legal, so name them
	assign ctrl_wr = wmerge(32'(ctrl_ff), pwdata, pstrb);
	assign mask_wr = wmerge(32'(irq_mask_ff), pwdata, pstrb);
	assign peek_wr = wmerge({20'h0, peek_sel_ff, 3'h0, peek_pos_ff}, pwdata, pstrb);

	// Control, mask and sticky status; read clears, new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `CTRL_RST;
			irq_mask_ff <= `MASK_RST;
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
			peek_sel_ff <= '0;
			peek_pos_ff <= '0;
		end else begin
			if (acc_wr && paddr == `OFF_CTRL) begin
				ctrl_ff <= ctrl_wr[`CTRL_W-1:0];
			end
			if (acc_wr && paddr == `OFF_IRQ_MASK) begin
				irq_mask_ff <= mask_wr[`NUM_EV-1:0];
			end
			if (acc_wr && paddr == `OFF_PEEK) begin
				peek_sel_ff <= peek_wr[11:8];
				peek_pos_ff <= peek_wr[4:0];
			end
			if (acc_rd && paddr == `OFF_IRQ_STAT) begin
				// Clear only what the read returned; an event in the wait state survives
				irq_stat_ff <= (irq_stat_ff & ~prdata_ff[`NUM_EV-1:0]) | ev;
			end else begin
				irq_stat_ff <= irq_stat_ff | ev;
			end
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// Read mux; out-of-range peeks read as zero
	always_comb begin
		peek_char = '0;
		if (peek_sel_ff < 4'(`NUM_LABELS) && peek_pos_ff < 5'(`NAME_LEN)) begin
			peek_char = name_mem[name_idx(peek_sel_ff, peek_pos_ff)];
		end
		rd_hit = 1'b1;
		case (paddr)
			`OFF_CTRL: rd_mux = 32'(ctrl_ff);
			`OFF_STATUS: rd_mux = {16'h0, 4'h0, cnt_odd_ff, alarm_b_ff, alarm_a_ff, trip_ff,
				contactor_b_ff, contactor_a_ff};
			`OFF_IRQ_STAT: rd_mux = 32'(irq_stat_ff);
			`OFF_IRQ_MASK: rd_mux = 32'(irq_mask_ff);
			`OFF_EDIT: rd_mux = {8'h0, edit_char_ff, 3'h0, cursor_ff, 4'h0, edit_sel_ff};
			`OFF_PEEK: rd_mux = {8'h0, peek_char, 4'h0, peek_sel_ff, 3'h0, peek_pos_ff};
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// APB slave: one wait state, answer registered
	assign acc_done = psel && penable && (apb_st_ff == APB_ACK);
	assign acc_wr = acc_done && pwrite && !pslverr_ff;
	assign acc_rd = acc_done && !pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_st_ff <= APB_IDLE;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
			pready_ff <= 1'b0;
		end else begin
			case (apb_st_ff)
				APB_IDLE: begin
					pready_ff <= psel && penable;
					if (psel && penable) begin
						apb_st_ff <= APB_ACK;
						prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
						pslverr_ff <= !rd_hit || (pwrite && paddr == `OFF_STATUS);
					end
				end
				APB_ACK: begin
					apb_st_ff <= APB_IDLE;
					pready_ff <= 1'b0;
				end
				default: apb_st_ff <= APB_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_fault_first;
		(kp[`K_FAULT_A] || kp[`K_FAULT_B]) && ds_en && auto_mode && !alarm_a_ff && !alarm_b_ff
			&& !any_trip;
	endsequence
	sequence s_store_key;
		ctrl_ff[`CB_EDIT] && kp[`K_STORE] && !acc_wr;
	endsequence

	property p_travel_a;
		!sw_ff[`SW_TRAVEL_A] |=> !contactor_a_ff;
	endproperty
	a_travel_a: assert property (p_travel_a) else $error("A ran with limit open");
	property p_reject_a;
		!sw_ff[`SW_TRAVEL_A] |-> !go_a;
	endproperty
	a_reject_a: assert property (p_reject_a) else $error("A start accepted");
	property p_travel_b;
		!sw_ff[`SW_TRAVEL_B] |-> !go_b ##1 !contactor_b_ff;
	endproperty
	a_travel_b: assert property (p_travel_b) else $error("B ran with limit open");
	property p_key_dead;
		remote_en && !ctrl_ff[`CB_LOCK_RST] && trip_ff[`T_LOCK] && !rise[`SW_CLEAR]
			|=> trip_ff[`T_LOCK];
	endproperty
	a_key_dead: assert property (p_key_dead) else $error("Panel reset cleared trip");
	property p_lock_own;
		ctrl_ff[`CB_LOCK_RST] && trip_ff[`T_LOCK] && !sw_ff[`SW_RST_LOCK] |=> trip_ff[`T_LOCK];
	endproperty
	a_lock_own: assert property (p_lock_own) else $error("Lockout cleared wrongly");
	property p_manual_sel;
		ds_en && !auto_mode && (go_a || go_b) |-> go_b == sw_ff[`SW_UNIT];
	endproperty
	a_manual_sel: assert property (p_manual_sel) else $error("Wrong manual motor");
	property p_alternate;
		ds_en && auto_mode && !alarm_a_ff && !alarm_b_ff && (go_a || go_b)
			|-> go_b == cnt_odd_ff ##1 cnt_odd_ff != $past(cnt_odd_ff);
	endproperty
	a_alternate: assert property (p_alternate) else $error("Alternation broken");
	property p_barred;
		alarm_a_ff |-> !go_a;
	endproperty
	a_barred: assert property (p_barred) else $error("Barred motor started");
	property p_to_alarm;
		s_fault_first |=> (alarm_a_ff || alarm_b_ff) && !trip_ff[`T_LOCK];
	endproperty
	a_to_alarm: assert property (p_to_alarm) else $error("Trip not made alarm");
	property p_second;
		ds_en && auto_mode && ((alarm_a_ff && kp[`K_FAULT_B]) || (alarm_b_ff && kp[`K_FAULT_A]))
			|=> trip_ff[`T_LOCK];
	endproperty
	a_second: assert property (p_second) else $error("Second trip lost");
	property p_iso;
		sw_ff[`SW_ISO] && !trip_set[`T_ISO] |=> !trip_ff[`T_ISO];
	endproperty
	a_iso: assert property (p_iso) else $error("Isolator trip stuck");
	property p_discard;
		scan_tick && !scan_ok |=> $stable(sw_ff) && !upd_ff;
	endproperty
	a_discard: assert property (p_discard) else $error("Bad scan committed");
	property p_advance;
		s_store_key ##0 (cursor_ff < 5'(`NAME_LEN - 1)) |=> cursor_ff == $past(cursor_ff) + 5'h01;
	endproperty
	a_advance: assert property (p_advance) else $error("Cursor not advanced");
	property p_wrap;
		s_store_key ##0 (cursor_ff == 5'(`NAME_LEN - 1)) |=> cursor_ff == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Cursor did not wrap");
endmodule : duty_standby_interlock_logic

//--- sim/field_contacts_model.sv
// Field switch contacts and contactor relay model for the interlock bench
module field_contacts_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic contactor_a,
	input wire logic contactor_b,
	output logic [14:0] sw
);
	timeunit 1ns;
	timeprecision 1ps;
	int closes_a; // Relay A pull-ins since reset
	int closes_b; // Relay B pull-ins since reset
	logic a_q; // Relay states one clock back
	logic b_q;
	// Healthy contacts closed; starts, selectors, clear and resets open
	initial sw = 15'h4783;
	// Pull-in counts show how starts were spread over the two starters
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			closes_a <= 0;
			closes_b <= 0;
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= contactor_a;
			b_q <= contactor_b;
			closes_a <= closes_a + int'(contactor_a & ~a_q);
			closes_b <= closes_b + int'(contactor_b & ~b_q);
		end
	end
	// A contact moves after an edge and holds past a scan plus sync
	task automatic put(input int i, input logic v);
		@(posedge pclk);
		sw[i] <= v;
		repeat (24) @(posedge pclk);
	endtask : put
endmodule : field_contacts_model

//--- sim/duty_standby_interlock_logic_tb.sv
// Self-checking bench for the duty/standby interlock logic
`include "dsi_map.svh"
module duty_standby_interlock_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0; // 125 MHz clock
	logic presetn = 1'b0; // Low from time zero
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [14:0] sw; // Field contacts from the partner
	logic [9:0] key = 10'h000; // Keys and fault events
	logic contactor_a, contactor_b, trip_ind, alarm_ind, irq;
	logic [31:0] rd; // Last read data
	logic er; // Last slave error
	int n_mismatch = 0;
	int cmp_count = 0;
	always #4 pclk = ~pclk;
	// Short scan so each settle is a few dozen clocks
	duty_standby_interlock_logic #(.SCAN_CYCLES(8)) u_duty_standby_interlock_logic (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .travel_a_in(sw[0]), .travel_b_in(sw[1]), .trip_clear_in(sw[2]),
		.unit_choice_input(sw[3]), .alternation_mode_input(sw[4]), .start_a_in(sw[5]),
		.start_b_in(sw[6]), .isolator_in(sw[7]), .plant_in(sw[8]), .process_stop_in(sw[9]),
		.emergency_shutdown(sw[10]), .uc_reset_in(sw[11]), .esd_reset_in(sw[12]),
		.lockout_reset_in(sw[13]), .sense_in(sw[14]), .key_reset(key[0]),
		.key_start_a(key[1]), .key_start_b(key[2]), .key_stop(key[3]), .key_up(key[4]),
		.key_down(key[5]), .key_store(key[6]), .fault_a(key[7]), .fault_b(key[8]),
		.undercurrent_fault(key[9]), .contactor_a(contactor_a), .contactor_b(contactor_b),
		.trip_ind(trip_ind), .alarm_ind(alarm_ind), .irq(irq)
	);
	field_contacts_model u_field_contacts_model (
		.pclk(pclk), .presetn(presetn), .contactor_a(contactor_a), .contactor_b(contactor_b),
		.sw(sw)
	);
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 32; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 32) begin
			n_mismatch++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Key held long enough for the synchroniser, then released
	task automatic press(input int k);
		@(posedge pclk);
		key[k] <= 1'b1;
		repeat (3) @(posedge pclk);
		key[k] <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask : press
	task automatic fs(input int i, input logic v);
		u_field_contacts_model.put(i, v);
	endtask : fs
	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (24) @(posedge pclk);
	endtask : do_reset
	// Reset values, read-only status, unmapped hole
	task automatic s_regs;
		apb(0, `OFF_CTRL, 0);
		chk(rd, 32'h0);
		apb(0, `OFF_IRQ_MASK, 0);
		chk(rd, 32'h0);
		apb(1, `OFF_STATUS, 32'hFFF);
		chk(er, 1'b1);
		apb(0, 12'hFFC, 0);
		chk({rd[30:0], er}, 32'h1);
	endtask : s_regs
	task automatic s_iso;
		fs(7, 0);
		chk(trip_ind, 1'b1);
		fs(7, 1);
		chk(trip_ind, 1'b0);
	endtask : s_iso
	// Each travel limit drops its relay and blocks its start
	task automatic s_travel;
		for (int s = 0; s < 2; s++) begin
			press(1 + s);
			chk(s ? contactor_b : contactor_a, 1'b1);
			fs(s, 0);
			chk({contactor_a, contactor_b}, 2'b00);
			press(1 + s);
			chk({contactor_a, contactor_b}, 2'b00);
			fs(s, 1);
		end
	endtask : s_travel
	// Panel reset disabled; wired clear skips lockouts with own reset
	task automatic s_lock;
		apb(1, `OFF_CTRL, 32'h02);
		press(7);
		press(0);
		chk(trip_ind, 1'b1);
		fs(2, 1);
		chk(trip_ind, 1'b0);
		fs(2, 0);
		apb(1, `OFF_CTRL, 32'h22);
		press(7);
		fs(2, 1);
		chk(trip_ind, 1'b1);
		fs(13, 1);
		chk(trip_ind, 1'b0);
		fs(2, 0);
		fs(13, 0);
	endtask : s_lock
	task automatic s_manual;
		apb(1, `OFF_CTRL, 32'h01);
		for (int u = 0; u < 2; u++) begin
			fs(3, u[0]);
			press(1);
			chk({contactor_a, contactor_b}, u ? 2'b01 : 2'b10);
			press(3);
		end
		fs(3, 0);
	endtask : s_manual
	// Bad sense discards scans and raises the masked event
	task automatic s_sense;
		apb(1, `OFF_CTRL, 32'h04);
		apb(1, `OFF_IRQ_MASK, 32'h4);
		fs(14, 0);
		fs(7, 0);
		chk({trip_ind, irq}, 2'b01);
		apb(0, `OFF_IRQ_STAT, 0);
		chk(rd[2], 1'b1);
		apb(1, `OFF_IRQ_MASK, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		fs(14, 1);
		chk(trip_ind, 1'b1);
		apb(0, `OFF_IRQ_STAT, 0);
		apb(0, `OFF_IRQ_STAT, 0);
		chk(rd[2], 1'b0);
		fs(7, 1);
	endtask : s_sense
	task automatic s_edit;
		apb(1, `OFF_CTRL, 32'h40);
		apb(1, `OFF_EDIT, 32'd11);
		press(4);
		press(4);
		press(5);
		press(6);
		apb(1, `OFF_PEEK, 32'hB00);
		apb(0, `OFF_PEEK, 0);
		chk(rd[23:16], `CHAR_SPACE + 8'h01);
		apb(0, `OFF_EDIT, 0);
		chk(rd[12:8], 5'd1);
		repeat (`NAME_LEN - 1) press(6);
		apb(0, `OFF_EDIT, 0);
		chk({rd[12:8], rd[3:0]}, {5'd0, 4'd11});
	endtask : s_edit
	// Parity from a fresh reset, trip handover, latched process stop
	task automatic s_auto;
		do_reset();
		apb(1, `OFF_CTRL, 32'h01);
		fs(4, 1);
		press(1);
		chk({contactor_a, contactor_b}, 2'b10);
		press(3);
		press(1);
		chk({contactor_a, contactor_b}, 2'b01);
		press(8);
		chk({trip_ind, alarm_ind, contactor_b}, 3'b010);
		for (int n = 0; n < 2; n++) begin
			press(3);
			press(1);
			chk({contactor_a, contactor_b}, 2'b10);
		end
		press(7);
		chk({trip_ind, contactor_a}, 2'b10);
		chk(u_field_contacts_model.closes_a * 16 + u_field_contacts_model.closes_b, 32'h31);
		press(0);
		chk({trip_ind, alarm_ind}, 2'b00);
		apb(1, `OFF_CTRL, 32'h81);
		fs(9, 0);
		fs(9, 1);
		chk(trip_ind, 1'b1);
		press(0);
		chk(trip_ind, 1'b0);
	endtask : s_auto
	initial begin
		do_reset();
		chk(trip_ind, 1'b0);
		s_regs();
		s_iso();
		s_travel();
		s_lock();
		s_manual();
		s_sense();
		s_edit();
		s_auto();
		end_of_test();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		end_of_test();
	end
endmodule : duty_standby_interlock_logic_tb
